// ===== core/upcount_timer.v
// basic 16-bit up-counting timer: register file, prescaler, counter, trigger out
// assumes an APB master on clk; slave update may come from another clock domain
`timescale 1ns/1ps
`include "upcount_timer_defs.vh"

// What this block does
// - registers at word offsets 0x00 to 0x34, at most sixteen bits wide each.
// - counter advances only while count_run, control_one bit 0, is set.
// - update_block high suppresses every update event source.
// - update event loads buffered reload and divider into active copies.
// - update_source_select high lets only overflow raise irq or dma.
// - one_shot clears count_run at the next update event.
// - reload_buffer_on low makes reload writes act on the counter at once.
// - master_out_select picks reset, count_run or update event for trigger.
// - irq_dma_enable bit 0 gates update_irq, bit 8 gates dma request.
// - counter counts up from zero, wraps at reload with overflow update.
// - prescaler divides clock by programmed divider plus one.
// - update event, or only overflow while update_source_select is high, sets update_flag, held until software clears it.
// - update_request reinitializes counter and prescaler, makes update, self-clears.
module upcount_timer (
   input wire clk,
   input wire sys_rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire slave_update,
   output wire trigger_output,
   output wire update_irq,
   output reg update_dma_req,
   output wire irq
);
   reg [15:0] control_one;
   reg [15:0] control_two;
   reg [15:0] irq_dma_enable;
   reg update_flag;
   reg [15:0] count_value;
   reg [15:0] clock_divider;
   reg [15:0] divider_active;
   reg [15:0] reload_value;
   reg [15:0] reload_active;
   reg [15:0] prescale_count;
   reg [1:0] irq_status;
   reg [1:0] irq_mask;
   reg [1:0] slave_sync;
   reg reset_pulse;
   reg update_pulse;
   wire slave_update_s;
   wire wr;
   wire rd;
   wire lo_ok;
   wire count_run;
   wire update_block;
   wire update_source_select;
   wire one_shot;
   wire reload_buffer_on;
   wire [2:0] master_out_select;
   wire [15:0] wdata;
   wire sw_request;
   wire tick;
   wire overflow;
   wire raw_update;
   wire update_event;
   wire qualified;
   wire [15:0] reload_eff;
   wire [1:0] evt;
   reg mapped;
   reg trigger_sel;
   wire [1:0] next_irq_status;
   wire write_control_one;
   wire write_control_two;
   wire write_irq_dma_enable;
   wire write_status_flags;
   wire write_event_generate;
   wire write_count_value;
   wire write_clock_divider;
   wire write_reload_value;
   wire write_irq_status;
   wire write_irq_mask;

   // zero-wait APB slave; any byte strobe in the low half writes the 16-bit register
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign wr = psel & penable & pwrite & mapped;
   assign rd = psel & ~penable & ~pwrite;
   assign lo_ok = pstrb[0] | pstrb[1];
   assign wdata = pwdata[15:0];

   // one write strobe per register keeps the decode in one place
   // a write needs a strobe in the low half because no register is wider than sixteen bits
   assign write_control_one = wr & lo_ok & (paddr == `OFS_CONTROL_ONE);
   assign write_control_two = wr & lo_ok & (paddr == `OFS_CONTROL_TWO);
   assign write_irq_dma_enable = wr & lo_ok & (paddr == `OFS_IRQ_DMA_ENABLE);
   assign write_status_flags = wr & lo_ok & (paddr == `OFS_STATUS_FLAGS);
   assign write_event_generate = wr & lo_ok & (paddr == `OFS_EVENT_GENERATE);
   assign write_count_value = wr & lo_ok & (paddr == `OFS_COUNT_VALUE);
   assign write_clock_divider = wr & lo_ok & (paddr == `OFS_CLOCK_DIVIDER);
   assign write_reload_value = wr & lo_ok & (paddr == `OFS_RELOAD_VALUE);
   assign write_irq_status = wr & lo_ok & (paddr == `OFS_IRQ_STATUS);
   assign write_irq_mask = wr & lo_ok & (paddr == `OFS_IRQ_MASK);

   // control field aliases
   assign count_run = control_one[`BIT_COUNT_RUN];
   assign update_block = control_one[`BIT_UPDATE_BLOCK];
   assign update_source_select = control_one[`BIT_UPDATE_SOURCE_SELECT];
   assign one_shot = control_one[`BIT_ONE_SHOT];
   assign reload_buffer_on = control_one[`BIT_RELOAD_BUFFER_ON];
   assign master_out_select = control_two[`BIT_MOS_HI:`BIT_MOS_LO];

   // slave update comes from another timer domain, so it is synchronised
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         slave_sync <= 2'h0;
      end else begin
         slave_sync <= {slave_sync[0], slave_update};
      end
   end
   assign slave_update_s = slave_sync[1];

   // address decode
   always @* begin
      if (paddr == `OFS_CONTROL_ONE) begin
         mapped = 1'b1;
      end else if (paddr == `OFS_CONTROL_TWO) begin
         mapped = 1'b1;
      end else if (paddr == `OFS_IRQ_DMA_ENABLE) begin
         mapped = 1'b1;
      end else if (paddr == `OFS_STATUS_FLAGS) begin
         mapped = 1'b1;
      end else if (paddr == `OFS_EVENT_GENERATE) begin
         mapped = 1'b1;
      end else if (paddr == `OFS_COUNT_VALUE) begin
         mapped = 1'b1;
      end else if (paddr == `OFS_CLOCK_DIVIDER) begin
         mapped = 1'b1;
      end else if (paddr == `OFS_RELOAD_VALUE) begin
         mapped = 1'b1;
      end else if (paddr == `OFS_IRQ_STATUS) begin
         mapped = 1'b1;
      end else if (paddr == `OFS_IRQ_MASK) begin
         mapped = 1'b1;
      end else begin
         mapped = 1'b0;
      end
   end

   // event sources
   assign sw_request = write_event_generate & wdata[`BIT_UPDATE_REQUEST];
   // tick marks the last timer clock of each divided counter period
   assign tick = count_run & (prescale_count == divider_active);
   // a reload of zero is never taken as a wrap point, so the counter rolls over at FFFF with no overflow then
   assign reload_eff = reload_active;
   assign overflow = tick & (count_value == reload_eff) & (reload_eff != 16'h0000);
   assign raw_update = overflow | sw_request | slave_update_s;
   assign update_event = raw_update & ~update_block;
   assign qualified = update_source_select ? (overflow & ~update_block)
                                           : update_event;
   assign evt = {overflow & ~update_block, qualified};

   // own sticky status bits, one per event; set wins over a write-one clear
   genvar b;
   generate
      for (b = 0; b < 2; b = b + 1) begin : status_bit
         assign next_irq_status[b] = evt[b] | (irq_status[b] & ~(write_irq_status & wdata[b]));
      end
   endgenerate

   // prescaler and counter
   // a software or slave reinitialisation outranks a counter write and counting
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         prescale_count <= `RST_REG16;
         count_value <= `RST_REG16;
         divider_active <= `RST_REG16;
         reload_active <= `RST_RELOAD;
      end else begin
         if (update_event) begin
            divider_active <= clock_divider;
         end
         if (write_reload_value & ~reload_buffer_on) begin
            reload_active <= wdata;
         end else if (update_event) begin
            reload_active <= reload_value;
         end
         if (sw_request | (slave_update_s & ~update_block)) begin
            prescale_count <= 16'h0000;
            count_value <= 16'h0000;
         end else if (write_count_value) begin
            count_value <= wdata;
         end else if (count_run) begin
            if (tick) begin
               prescale_count <= 16'h0000;
               count_value <= overflow ? 16'h0000 : count_value + 16'h0001;
            end else begin
               prescale_count <= prescale_count + 16'h0001;
            end
         end
      end
   end

   // register writes, one-shot stop and sticky flags
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         control_one <= `RST_REG16;
         control_two <= `RST_REG16;
         irq_dma_enable <= `RST_REG16;
         clock_divider <= `RST_REG16;
         reload_value <= `RST_RELOAD;
         update_flag <= 1'b0;
         irq_status <= `RST_EVT;
         irq_mask <= `RST_EVT;
      end else begin
         // reserved bits are masked so that they always read back zero
         if (write_control_one) begin
            control_one <= wdata & 16'h008F;
         end else if (update_event & one_shot) begin
            control_one[`BIT_COUNT_RUN] <= 1'b0;
         end
         if (write_control_two) begin
            control_two <= wdata & 16'h0070;
         end
         if (write_irq_dma_enable) begin
            irq_dma_enable <= wdata & 16'h0101;
         end
         if (write_clock_divider) begin
            clock_divider <= wdata;
         end
         if (write_reload_value) begin
            reload_value <= wdata;
         end
         if (write_irq_mask) begin
            irq_mask <= wdata[1:0];
         end
         // set wins over a clear in the same cycle
         if (qualified) begin
            update_flag <= 1'b1;
         end else if (write_status_flags & ~wdata[`BIT_UPDATE_FLAG]) begin
            update_flag <= 1'b0;
         end
         irq_status <= next_irq_status;
      end
   end

   // trigger sources, dma pulse and read data registered
   // read data is captured in the setup phase and stands through the access phase
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         reset_pulse <= 1'b0;
         update_pulse <= 1'b0;
         update_dma_req <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         reset_pulse <= sw_request & ~update_block;
         update_pulse <= update_event;
         update_dma_req <= qualified & irq_dma_enable[`BIT_UPDATE_DMA_ON];
         if (rd) begin
            if (paddr == `OFS_CONTROL_ONE) begin
               prdata <= {16'h0000, control_one};
            end else if (paddr == `OFS_CONTROL_TWO) begin
               prdata <= {16'h0000, control_two};
            end else if (paddr == `OFS_IRQ_DMA_ENABLE) begin
               prdata <= {16'h0000, irq_dma_enable};
            end else if (paddr == `OFS_STATUS_FLAGS) begin
               prdata <= {31'h00000000, update_flag};
            end else if (paddr == `OFS_COUNT_VALUE) begin
               prdata <= {16'h0000, count_value};
            end else if (paddr == `OFS_CLOCK_DIVIDER) begin
               prdata <= {16'h0000, clock_divider};
            end else if (paddr == `OFS_RELOAD_VALUE) begin
               prdata <= {16'h0000, reload_value};
            end else if (paddr == `OFS_IRQ_STATUS) begin
               prdata <= {30'h00000000, irq_status};
            end else if (paddr == `OFS_IRQ_MASK) begin
               prdata <= {30'h00000000, irq_mask};
            end else begin
               prdata <= 32'h00000000; // event register reads zero
            end
         end
      end
   end

   // master trigger output; reserved codes give low
   // pulses last one clock so that a downstream timer sees each event once
   always @* begin
      case (master_out_select)
         `MOS_RESET: begin
            trigger_sel = reset_pulse;
         end
         `MOS_ENABLE: begin
            trigger_sel = count_run;
         end
         `MOS_UPDATE: begin
            trigger_sel = update_pulse;
         end
         default: begin
            trigger_sel = 1'b0;
         end
      endcase
   end
   assign trigger_output = trigger_sel;
   // the interrupt is a level so that a pending update cannot be missed
   assign update_irq = update_flag & irq_dma_enable[`BIT_UPDATE_IRQ_ON];
   assign irq = |(irq_status & irq_mask);
endmodule

// ===== pkg/upcount_timer_defs.vh
// register offsets, field positions and reset values of the up-counting timer
// assumes inclusion by bare name from the design file
`ifndef UPCOUNT_TIMER_DEFS_VH
`define UPCOUNT_TIMER_DEFS_VH
`define OFS_CONTROL_ONE 12'h000
`define OFS_CONTROL_TWO 12'h004
`define OFS_IRQ_DMA_ENABLE 12'h00C
`define OFS_STATUS_FLAGS 12'h010
`define OFS_EVENT_GENERATE 12'h014
`define OFS_COUNT_VALUE 12'h024
`define OFS_CLOCK_DIVIDER 12'h028
`define OFS_RELOAD_VALUE 12'h02C
`define OFS_IRQ_STATUS 12'h030
`define OFS_IRQ_MASK 12'h034
`define BIT_COUNT_RUN 0
`define BIT_UPDATE_BLOCK 1
`define BIT_UPDATE_SOURCE_SELECT 2
`define BIT_ONE_SHOT 3
`define BIT_RELOAD_BUFFER_ON 7
`define BIT_MOS_LO 4
`define BIT_MOS_HI 6
`define BIT_UPDATE_IRQ_ON 0
`define BIT_UPDATE_DMA_ON 8
`define BIT_UPDATE_FLAG 0
`define BIT_UPDATE_REQUEST 0
`define BIT_EVT_UPDATE 0
`define BIT_EVT_OVERFLOW 1
`define MOS_RESET 3'h0
`define MOS_ENABLE 3'h1
`define MOS_UPDATE 3'h2
`define RST_REG16 16'h0000
`define RST_RELOAD 16'hFFFF
`define RST_EVT 2'h0
`endif

// ===== verification/upcount_timer_properties.sv
// port checker of the up-counting timer
// assumes a bind onto upcount_timer, one clock domain
`timescale 1ns/1ps
module upcount_timer_properties (
   input wire clk,
   input wire sys_rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   input wire [31:0] prdata,
   input wire pslverr,
   input wire trigger_output,
   input wire update_irq,
   input wire update_dma_req
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   reg blk;
   reg [2:0] mos;
   wire acc = psel && penable;
   wire wr = acc && pwrite && (pstrb[0] || pstrb[1]);
   wire rd = acc && !pwrite;
   // shadow of update block bit and trigger source code
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         blk <= 1'b0;
         mos <= 3'h0;
      end else if (wr && paddr == 12'h000) begin
         blk <= pwdata[1];
      end else if (wr && paddr == 12'h004) begin
         mos <= pwdata[6:4];
      end
   end
   property p_slverr; acc && paddr == 12'h008 |-> pslverr; endproperty
   a_slverr: assert property (p_slverr) else $error("no slave error");
   property p_evt_rd; rd && paddr == 12'h014 |-> prdata == 32'h0; endproperty
   a_evt_rd: assert property (p_evt_rd) else $error("event reg not zero");
   property p_rsv; rd && paddr == 12'h004 |-> prdata[31:7] == 25'h0 && prdata[3:0] == 4'h0;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits set");
   property p_irq_off; wr && paddr == 12'h00C && !pwdata[0] |=> !update_irq; endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq not gated");
   property p_dma_off; wr && paddr == 12'h00C && !pwdata[8] |-> ##2 !update_dma_req; endproperty
   a_dma_off: assert property (p_dma_off) else $error("dma not gated");
   property p_trig_req; wr && paddr == 12'h014 && pwdata[0] && !blk && mos == 3'h0
      |-> ##[1:2] trigger_output; endproperty
   a_trig_req: assert property (p_trig_req) else $error("no trigger");
   property p_trig_blk; wr && paddr == 12'h014 && blk && mos == 3'h2
      |=> !trigger_output [*2]; endproperty
   a_trig_blk: assert property (p_trig_blk) else $error("blocked update seen");
   property p_dma_pulse; update_dma_req |=> !update_dma_req; endproperty
   a_dma_pulse: assert property (p_dma_pulse) else $error("dma not a pulse");
   c_trig: cover property (trigger_output);
   c_dma: cover property (update_dma_req);
   c_irq: cover property (update_irq);
endmodule

// ===== verification/timer_far_side.sv
// far-side model: downstream timer on the trigger and a dma engine
// assumes the timer clock is shared
`timescale 1ns/1ps
module timer_far_side (
   input wire clk,
   input wire trigger_output,
   input wire update_dma_req,
   output reg slave_update,
   output int trig_n,
   output int dma_n
);
   initial begin
      slave_update = 1'b0;
      trig_n = 0;
      dma_n = 0;
   end
   // count cycles with trigger and dma request high
   always @(posedge clk) begin
      if (trigger_output === 1'b1) trig_n <= trig_n + 1;
      if (update_dma_req === 1'b1) dma_n <= dma_n + 1;
   end
   // one-cycle update request from a slave controller
   task kick;
      slave_update <= 1'b1;
      @(posedge clk);
      slave_update <= 1'b0;
   endtask
endmodule

// ===== verification/upcount_timer_test.sv
// self-checking bench of the up-counting timer over apb
// assumes the far-side model and the bound port checker
`timescale 1ns/1ps
module upcount_timer_test;
   reg clk = 1'b0;
   reg sys_rst = 1'b1;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0;
   reg [3:0] pstrb = 4'h0;
   wire [31:0] prdata;
   wire pready, pslverr, slave_update, trigger_output, update_irq, update_dma_req, irq;
   reg [31:0] got;
   int miscompares = 0, check_count = 0, cyc = 0, i, n, m, trig_n, dma_n;
   logic [11:0] ofs [8] = '{12'h000, 12'h004, 12'h00C, 12'h010, 12'h024, 12'h028,
      12'h02C, 12'h008};
   upcount_timer upcount_timer_i (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb, .prdata, .pready, .pslverr, .slave_update, .trigger_output,
      .update_irq, .update_dma_req, .irq);
   timer_far_side timer_far_side_i (.clk, .trigger_output, .update_dma_req,
      .slave_update, .trig_n, .dma_n);
   initial forever #5 clk = ~clk;
   task print_verdict;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task cmp(input bit ok);
      check_count++;
      if (!ok) begin
         miscompares++;
         $display("unexpected at %0t: check %0d", $time, check_count);
      end
   endtask
   // one apb transfer, then an idle cycle
   task xfer(input bit w, input [11:0] a, input [15:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      pstrb <= {4{w}};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      got = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task wr(input [11:0] a, input [15:0] d);
      xfer(1'b1, a, d);
   endtask
   task rd(input [11:0] a, input [15:0] e);
      xfer(1'b0, a, 16'h0000);
      cmp(got === {16'h0000, e});
   endtask
   task run(input [15:0] c);
      wr(12'h000, c);
      repeat (40) @(posedge clk);
      wr(12'h000, c & 16'hFFFE);
      xfer(1'b0, 12'h024, 16'h0000);
   endtask
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         print_verdict;
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      for (i = 0; i < 8; i++) rd(ofs[i], i == 6 ? 16'hFFFF : 16'h0000);
      wr(12'h00C, 16'h0101);
      wr(12'h034, 16'h0001);
      wr(12'h02C, 16'h0003);
      run(16'h0001);
      cmp(got[15:0] < 16'h0004);
      rd(12'h010, 16'h0001);
      cmp(update_irq === 1'b1 && irq === 1'b1 && dma_n > 0);
      wr(12'h010, 16'h0000);
      wr(12'h030, 16'h0003);
      rd(12'h010, 16'h0000);
      cmp(update_irq === 1'b0 && irq === 1'b0);
      wr(12'h02C, 16'hFFFF);
      wr(12'h028, 16'h0003);
      wr(12'h024, 16'h0000);
      run(16'h0001);
      cmp(got[15:0] > 16'h001E);
      wr(12'h014, 16'h0001);
      rd(12'h024, 16'h0000);
      rd(12'h014, 16'h0000);
      run(16'h0001);
      cmp(got[15:0] > 16'h0008 && got[15:0] < 16'h000E);
      wr(12'h000, 16'h0080);
      wr(12'h02C, 16'h0002);
      wr(12'h024, 16'h0000);
      run(16'h0089);
      cmp(got[15:0] > 16'h0002);
      rd(12'h000, 16'h0088);
      wr(12'h014, 16'h0001);
      wr(12'h000, 16'h0089);
      repeat (40) @(posedge clk);
      rd(12'h000, 16'h0088);
      rd(12'h024, 16'h0000);
      for (i = 0; i < 4; i++) begin
         wr(12'h004, 16'(i) << 4);
         n = trig_n;
         wr(12'h000, 16'h0001);
         wr(12'h014, 16'h0001);
         wr(12'h000, 16'h0000);
         cmp((trig_n > n) === (i < 3));
      end
      wr(12'h004, 16'h0020);
      wr(12'h010, 16'h0000);
      wr(12'h000, 16'h0004);
      n = trig_n;
      m = dma_n;
      wr(12'h014, 16'h0001);
      rd(12'h010, 16'h0000);
      cmp(trig_n > n && dma_n == m);
      wr(12'h000, 16'h0002);
      n = trig_n;
      wr(12'h014, 16'h0001);
      rd(12'h010, 16'h0000);
      cmp(trig_n == n);
      wr(12'h000, 16'h0000);
      timer_far_side_i.kick();
      repeat (5) @(posedge clk);
      rd(12'h010, 16'h0001);
      wr(12'h00C, 16'h0000);
      cmp(update_irq === 1'b0);
      print_verdict;
   end
endmodule
bind upcount_timer upcount_timer_properties upcount_timer_properties_i (.clk, .sys_rst,
   .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pslverr, .trigger_output,
   .update_irq, .update_dma_req);
